// ### design/lsr_line_sense_readback.sv
// top: AHB-Lite register bank of line voltage and transistor current readings
//
// Design decision made here: the AHB-Lite interface to the registers.
module lsr_line_sense_readback
(
    // clock and reset
    input  wire  logic                        hclk,
    input  wire  logic                        hresetn,
    // AHB-Lite slave
    input  wire  logic                        hsel,
    input  wire  logic [31:0]                 haddr,
    input  wire  logic [1:0]                  htrans,
    input  wire  logic                        hwrite,
    input  wire  logic [2:0]                  hsize,
    input  wire  logic                        hready,
    input  wire  logic [lsr_pkg::DATA_W-1:0]  hwdata,
    output logic       [lsr_pkg::DATA_W-1:0]  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // measurement path codes
    input  wire  lsr_pkg::lsr_code_t          tip_voltage_code,
    input  wire  lsr_pkg::lsr_code_t          ring_voltage_code,
    input  wire  lsr_pkg::lsr_code_t          battery_voltage_code_a,
    input  wire  lsr_pkg::lsr_code_t          battery_voltage_code_b,
    input  wire  lsr_pkg::lsr_code_t          transistor_one_current_code,
    input  wire  lsr_pkg::lsr_code_t          transistor_two_current_code,
    input  wire  lsr_pkg::lsr_code_t          transistor_three_current_code,
    input  wire  lsr_pkg::lsr_code_t          transistor_four_current_code,
    input  wire  lsr_pkg::lsr_code_t          transistor_five_current_code,
    input  wire  lsr_pkg::lsr_code_t          transistor_six_current_code,
    // per-channel sample strobes, bit order as channel numbers
    input  wire  logic [lsr_pkg::NUM_CHANNELS-1:0] sample_strobe,
    // extra bias current share of first two transistors
    input  wire  lsr_pkg::lsr_code_t          extra_bias_current,
    // extra bias enable towards the line feed
    output logic                              extra_bias_enable
);
    import lsr_pkg::*;

    // ============================================================
    // helper functions

    // word index out of a byte address
    function automatic logic [7:0] word_index(input logic [31:0] addr);
        word_index = addr[INDEX_MSB:INDEX_LSB];
    endfunction

    // code minus extra bias, floored at zero
    function automatic lsr_code_t sat_sub(input lsr_code_t a, input lsr_code_t b);
        sat_sub = (a > b) ? lsr_code_t'(a - b) : CODE_RESET;
    endfunction

    // ============================================================
    // control and status state
    logic                    freeze;
    logic [NUM_CHANNELS-1:0] fresh;

    // ============================================================
    // carrier to the capture bank
    lsr_sense_if sense ();

    lsr_sense_bank u_bank
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sense   (sense)
    );

    // ============================================================
    // measurement path into the bank
    lsr_code_t q1_base;
    lsr_code_t q2_base;

    // base current only while extra bias is on
    assign q1_base = extra_bias_enable
                   ? sat_sub(transistor_one_current_code, extra_bias_current)
                   : transistor_one_current_code;
    assign q2_base = extra_bias_enable
                   ? sat_sub(transistor_two_current_code, extra_bias_current)
                   : transistor_two_current_code;

    assign sense.strobe                 = sample_strobe;
    assign sense.freeze                 = freeze;
    assign sense.raw[CH_TIP]            = tip_voltage_code;
    assign sense.raw[CH_RING]           = ring_voltage_code;
    assign sense.raw[CH_BATTERY_A]      = battery_voltage_code_a;
    assign sense.raw[CH_BATTERY_B]      = battery_voltage_code_b;
    assign sense.raw[CH_TRANSISTOR_ONE] = q1_base;
    assign sense.raw[CH_TRANSISTOR_TWO] = q2_base;
    assign sense.raw[CH_TRANSISTOR_3]   = transistor_three_current_code;
    assign sense.raw[CH_TRANSISTOR_4]   = transistor_four_current_code;
    assign sense.raw[CH_TRANSISTOR_5]   = transistor_five_current_code;
    assign sense.raw[CH_TRANSISTOR_SIX] = transistor_six_current_code;

    // ============================================================
    // address phase decode
    logic       addr_phase;
    logic       rd_take;
    logic       wr_take;
    logic [7:0] a_idx;
    logic       a_upper_zero;
    logic       a_hit_sense;
    logic       a_hit_ctrl;
    logic       a_hit_stat;
    logic [3:0] a_sense_sel;

    assign addr_phase   = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign rd_take      = addr_phase & ~hwrite;
    assign wr_take      = addr_phase & hwrite;
    assign a_idx        = word_index(haddr);
    assign a_upper_zero = (haddr[31:INDEX_MSB+1] == '0);
    assign a_hit_sense  = a_upper_zero && (a_idx >= IDX_TIP_VOLTAGE)
                                       && (a_idx <= IDX_TRANSISTOR_SIX);
    assign a_hit_ctrl   = a_upper_zero && (a_idx == IDX_SENSE_CONTROL);
    assign a_hit_stat   = a_upper_zero && (a_idx == IDX_SENSE_STATUS);
    assign a_sense_sel  = 4'(a_idx - IDX_TIP_VOLTAGE);

    // ============================================================
    // read data selection
    logic [DATA_W-1:0] sense_word;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] next_hrdata;

    assign sense_word  = {{(DATA_W-CODE_W){1'b0}}, sense.held[a_sense_sel]};
    assign ctrl_word   = {{(DATA_W-2){1'b0}}, freeze, extra_bias_enable};
    assign stat_word   = {{(DATA_W-NUM_CHANNELS){1'b0}}, fresh};
    assign next_hrdata = !rd_take   ? '0
                       : a_hit_sense ? sense_word
                       : a_hit_ctrl  ? ctrl_word
                       : a_hit_stat  ? stat_word
                       : '0;

    // ============================================================
    // data phase of a write
    logic wr_pend;
    logic wr_ctrl;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_ctrl <= 1'b0;
        end
        else
        begin
            wr_pend <= wr_take;
            wr_ctrl <= wr_take & a_hit_ctrl;
        end
    end

    // ============================================================
    // control register; sense registers take no bus writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            extra_bias_enable <= CTRL_RESET[CTRL_BIAS_BIT];
            freeze            <= CTRL_RESET[CTRL_FREEZE_BIT];
        end
        else if (wr_pend && wr_ctrl)
        begin
            extra_bias_enable <= hwdata[CTRL_BIAS_BIT];
            freeze            <= hwdata[CTRL_FREEZE_BIT];
        end
    end

    // ============================================================
    // fresh flags: set on capture, cleared by a status read
    logic                    stat_read;
    logic [NUM_CHANNELS-1:0] next_fresh;

    assign stat_read  = rd_take & a_hit_stat;
    assign next_fresh = (stat_read ? '0 : fresh) | sense.updated;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fresh <= STATUS_RESET;
        else
            fresh <= next_fresh;
    end

    // ============================================================
    // bus answer, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
        else
        begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

endmodule // lsr_line_sense_readback

// ### design/lsr_pkg.sv
// package: register map, field layout and reset values of the line sense readback bank
package lsr_pkg;

    // ============================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_TIP_VOLTAGE     = 8'h50;
    localparam logic [7:0] IDX_RING_VOLTAGE    = 8'h51;
    localparam logic [7:0] IDX_BATTERY_A       = 8'h52;
    localparam logic [7:0] IDX_BATTERY_B       = 8'h53;
    localparam logic [7:0] IDX_TRANSISTOR_ONE  = 8'h54;
    localparam logic [7:0] IDX_TRANSISTOR_TWO  = 8'h55;
    localparam logic [7:0] IDX_TRANSISTOR_3    = 8'h56;
    localparam logic [7:0] IDX_TRANSISTOR_4    = 8'h57;
    localparam logic [7:0] IDX_TRANSISTOR_5    = 8'h58;
    localparam logic [7:0] IDX_TRANSISTOR_SIX  = 8'h59;
    localparam logic [7:0] IDX_SENSE_CONTROL   = 8'h5a;
    localparam logic [7:0] IDX_SENSE_STATUS    = 8'h5b;

    // ============================================================
    // sizes
    localparam int          NUM_CHANNELS      = 10;
    localparam int          CODE_W            = 8;
    localparam int          DATA_W            = 32;
    localparam int          INDEX_LSB         = 2;
    localparam int          INDEX_MSB         = 9;

    // channel numbers inside the bank
    localparam int          CH_TIP            = 0;
    localparam int          CH_RING           = 1;
    localparam int          CH_BATTERY_A      = 2;
    localparam int          CH_BATTERY_B      = 3;
    localparam int          CH_TRANSISTOR_ONE = 4;
    localparam int          CH_TRANSISTOR_TWO = 5;
    localparam int          CH_TRANSISTOR_3   = 6;
    localparam int          CH_TRANSISTOR_4   = 7;
    localparam int          CH_TRANSISTOR_5   = 8;
    localparam int          CH_TRANSISTOR_SIX = 9;

    // ============================================================
    // control field layout and reset values
    localparam int          CTRL_BIAS_BIT     = 0;
    localparam int          CTRL_FREEZE_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET        = 2'h0;
    localparam logic [7:0]  CODE_RESET        = 8'h00;
    localparam logic [9:0]  STATUS_RESET      = 10'h000;

    // ============================================================
    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ        = 2'h3;
    localparam logic        HRESP_OKAY        = 1'b0;

    typedef logic [CODE_W-1:0] lsr_code_t;

endpackage

// ### design/lsr_sense_if.sv
// interface: raw codes and held sense registers between top and capture bank
interface lsr_sense_if;
    import lsr_pkg::*;

    logic [NUM_CHANNELS-1:0] strobe;
    lsr_code_t               raw    [NUM_CHANNELS];
    lsr_code_t               held   [NUM_CHANNELS];
    logic                    freeze;
    logic [NUM_CHANNELS-1:0] updated;

    modport src  (output strobe, output raw, output freeze, input held, input updated);
    modport bank (input strobe, input raw, input freeze, output held, output updated);
endinterface

// ### design/lsr_sense_bank.sv
// capture bank: holds the latest sampled code of every sense channel
module lsr_sense_bank
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // sense channels
    lsr_sense_if.bank sense
);
    import lsr_pkg::*;

    // ============================================================
    // update enables
    logic [NUM_CHANNELS-1:0] take;

    assign take           = sense.strobe & {NUM_CHANNELS{~sense.freeze}};
    assign sense.updated  = take;

    // ============================================================
    // held codes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NUM_CHANNELS; i++)
                sense.held[i] <= CODE_RESET;
        end
        else
        begin
            for (int i = 0; i < NUM_CHANNELS; i++)
                if (take[i])
                    sense.held[i] <= sense.raw[i];
        end
    end

endmodule // lsr_sense_bank

// ### bench/lsr_line_sense_readback_asserts.sv
// checker: bus answer and readback timing of the line sense bank
module lsr_line_sense_readback_asserts
    import lsr_pkg::*;
(
    // clock, reset and bus
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic                    hready,
    input wire logic [DATA_W-1:0]       hwdata,
    input wire logic [DATA_W-1:0]       hrdata,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    // sense side
    input wire lsr_code_t               tip_voltage_code,
    input wire lsr_code_t               transistor_one_current_code,
    input wire logic [NUM_CHANNELS-1:0] sample_strobe,
    input wire lsr_code_t               extra_bias_current,
    input wire logic                    extra_bias_enable
);
    // ============================================================
    // bus decode and tracked freeze bit
    wire logic      tk     = hsel && hready && htrans[1];
    wire logic      rd     = tk && !hwrite;
    wire logic      rd_tip = rd && haddr == 32'h140;
    wire logic      rd_q1  = rd && haddr == 32'h150;
    wire logic      wb     = hwdata[CTRL_BIAS_BIT];
    wire lsr_code_t d1     = transistor_one_current_code - extra_bias_current;
    wire logic      lo     = transistor_one_current_code < extra_bias_current;
    wire lsr_code_t q1_exp = !extra_bias_enable ? transistor_one_current_code : lo ? 8'h00 : d1;
    logic           rd_dp;
    logic           wc_dp;
    logic           frz;
    lsr_code_t      q1_m;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_dp <= 1'b0;
            wc_dp <= 1'b0;
            frz   <= 1'b0;
            q1_m  <= 8'h00;
        end
        else
        begin
            rd_dp <= rd;
            wc_dp <= tk && hwrite && haddr == 32'h168;
            if (wc_dp)
                frz <= hwdata[CTRL_FREEZE_BIT];
            // expected first current register, base share only while bias is on
            if (sample_strobe[CH_TRANSISTOR_ONE] && !frz)
                q1_m <= q1_exp;
        end
    end

    // ============================================================
    // properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_okay; hresp == HRESP_OKAY; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_quiet; !rd_dp |-> hrdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside read");
    property p_unmap; rd && haddr[31:10] != 22'h0 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_upper; rd_dp |-> hrdata[31:10] == 22'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_tip;
        sample_strobe[CH_TIP] && !frz ##1 rd_tip |=> hrdata == {24'h0, $past(tip_voltage_code, 2)};
    endproperty
    a_tip: assert property (p_tip) else $error("tip code not captured");
    property p_q1; rd_q1 |=> hrdata[7:0] == $past(q1_m); endproperty
    a_q1: assert property (p_q1) else $error("first current code wrong");
    property p_ctl; wc_dp |=> extra_bias_enable == $past(wb); endproperty
    a_ctl: assert property (p_ctl) else $error("bias enable not written");

    c_tip: cover property (sample_strobe[CH_TIP] && !frz ##1 rd_tip);
    c_bias: cover property (wc_dp && wb);
    c_frz: cover property (frz && sample_strobe[CH_TIP]);
endmodule // lsr_line_sense_readback_asserts

bind lsr_line_sense_readback lsr_line_sense_readback_asserts u_asserts
(
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .tip_voltage_code, .transistor_one_current_code,
    .sample_strobe, .extra_bias_current, .extra_bias_enable
);

// ### bench/tb_line_sense_readback.sv
// testbench: random and corner readback of the line sense bank over AHB-Lite
module tb_line_sense_readback;
    timeunit 1ns;
    timeprecision 1ps;
    import lsr_pkg::*;

    logic             hclk, hresetn, hsel, hwrite, en, fz;
    logic [1:0]       htrans;
    logic [31:0]      haddr, hwdata, r;
    logic [9:0]       sample_strobe, fr;
    lsr_code_t        cd [NUM_CHANNELS];
    lsr_code_t        held [NUM_CHANNELS];
    lsr_code_t        bias;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, ebe;
    int               err_count, checks_done;

    lsr_line_sense_readback dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tip_voltage_code(cd[0]), .ring_voltage_code(cd[1]),
        .battery_voltage_code_a(cd[2]), .battery_voltage_code_b(cd[3]),
        .transistor_one_current_code(cd[4]), .transistor_two_current_code(cd[5]),
        .transistor_three_current_code(cd[6]), .transistor_four_current_code(cd[7]),
        .transistor_five_current_code(cd[8]), .transistor_six_current_code(cd[9]),
        .sample_strobe(sample_strobe), .extra_bias_current(bias),
        .extra_bias_enable(ebe)
    );

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // ============================================================
    // shared tasks and model
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ready_edge();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                err_count++;
                conclude();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] v);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        ready_edge();
        htrans <= 2'h0;
        hwdata <= d;
        ready_edge();
        v = hrdata;
    endtask

    function automatic logic [31:0] adr(input int i);
        return 32'({IDX_TIP_VOLTAGE + 8'(i), 2'b00});
    endfunction

    function automatic lsr_code_t expect_code(input int ch, input lsr_code_t c, input lsr_code_t b);
        if ((ch == CH_TRANSISTOR_ONE || ch == CH_TRANSISTOR_TWO) && en)
            return c > b ? c - b : 8'h00;
        return c;
    endfunction

    task automatic rd_all();
        logic [31:0] v;
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            bus(1'b0, adr(i), 32'h0, v);
            chk("sense", v, {24'h0, held[i]});
        end
    endtask

    // one capture pulse; first two rounds are all-ones and all-zero corners
    task automatic strobe(input int it);
        logic [9:0] m;
        lsr_code_t  c [NUM_CHANNELS];
        lsr_code_t  b;
        m = it < 2 ? 10'h3ff : 10'($urandom);
        b = it == 1 ? 8'hff : 8'($urandom);
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            c[i] = it < 2 ? {8{it == 0}} : 8'($urandom);
            if (m[i] && !fz)
                held[i] = expect_code(i, c[i], b);
            cd[i] <= c[i];
        end
        if (!fz)
            fr = fr | m;
        bias <= b;
        sample_strobe <= m;
        @(posedge hclk);
        sample_strobe <= 10'h0;
        bias <= ~b;
        for (int i = 0; i < NUM_CHANNELS; i++)
            cd[i] <= ~c[i];
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        int k;
        {hsel, hwrite, htrans, haddr, hwdata, sample_strobe, bias, en, fz, fr} = '0;
        cd = '{default: 8'h00};
        held = '{default: 8'h00};
        hresetn = 1'b0;
        void'($urandom(32'h399c));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd_all();
        for (int it = 0; it < 60; it++)
        begin
            en = 1'($urandom);
            fz = it > 1 && ($urandom % 4) == 0;
            bus(1'b1, 32'h168, {30'h0, fz, en}, r);
            strobe(it);
            chk("bias enable", {31'h0, ebe}, {31'h0, en});
            rd_all();
            bus(1'b0, 32'h168, 32'h0, r);
            chk("control", r, {30'h0, fz, en});
            bus(1'b0, 32'h16c, 32'h0, r);
            chk("status", r, {22'h0, fr});
            fr = '0;
            k = $urandom % NUM_CHANNELS;
            bus(1'b1, adr(k), $urandom, r);
            bus(1'b0, adr(k), 32'h0, r);
            chk("after write", r, {24'h0, held[k]});
            bus(1'b0, ($urandom | 32'h400) & 32'hffff_fffc, 32'h0, r);
            chk("unmapped", r, 32'h0);
        end
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        held = '{default: 8'h00};
        chk("bias after reset", {31'h0, ebe}, 32'h0);
        rd_all();
        bus(1'b0, 32'h16c, 32'h0, r);
        chk("status after reset", r, 32'h0);
        conclude();
    end
endmodule // tb_line_sense_readback
